// >>> uppsc_top.sv
// power-state decoder and switch sequencer of the port power controller
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: below core threshold (reset) hold all switches off, keep no state.
// RQ2: sleep turns all switches off and disables attach and removal detection.
// RQ3: entering sleep releases the fault alert and the attach flag.
// RQ4: sleep keeps decoding the mode inputs so they can wake the block.
// RQ5: sleep when enable off, select 0, not pass-through; or enable on, select 0, modes zero.
// RQ6: select 1 with enable off, or enable on and source low and modes nonzero: detect.
// RQ7: select 1, enable on, source good, modes nonzero: wait in detect, auto-activate on attach.
// RQ8: detect keeps port and data switches off and bus fed via bypass.
// RQ9: select 0, enable on, source good, plain mode: active, port on, data follows mode.
// RQ10: cycling mode keeps port on, data off, steps profiles while nothing attached.
// RQ11: active reached from detect keeps port on and removal detection enabled.
// RQ12: host changes mode inputs before enable when leaving pass-through for sleep.
// RQ13: enable on, select 1, modes zero: detect without discharge or attach detection.
// RQ14: host should use only the listed input combinations.
// RQ15: error turns all switches off, asserts the alert, keeps switches off meanwhile.
// RQ16: detect to active: stop attach detect, open bypass, pulse discharge, close port.
// RQ17: control inputs are synchronised before the state is decoded.
module uppsc_top #(
  parameter int TICK_CYCLES      = uppsc_pkg::TICK_CYCLES,
  parameter int DISCHARGE_MS     = uppsc_pkg::DISCHARGE_MS,
  parameter int PROFILE_DWELL_MS = uppsc_pkg::PROFILE_DWELL_MS,
  parameter int PROFILE_COUNT    = uppsc_pkg::PROFILE_COUNT
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RESETN,
  input  wire logic       I_SWITCH_ENABLE_INPUT,
  input  wire logic       I_ENABLE_POLARITY,
  input  wire logic       I_DETECT_SELECT,
  input  wire logic       I_MODE_SELECT_A,
  input  wire logic       I_MODE_SELECT_B,
  input  wire logic       I_EMULATION_ON,
  input  wire logic       I_SOURCE_SUPPLY_OK,
  input  wire logic       I_PORTABLE_PRESENT,
  input  wire logic       I_FAULT,
  output logic            O_PORT_SWITCH_ON,
  output logic            O_BYPASS_SWITCH_ON,
  output logic            O_HS_SWITCH_ON,
  output logic            O_DISCHARGE_ON,
  output logic            O_ATTACH_DETECT_EN,
  output logic            O_REMOVAL_DETECT_EN,
  output logic            O_ALERT_N_OUT,
  output logic            O_ALERT_N_OE,
  output logic            O_ATTACH_FLAG_N_OUT,
  output logic            O_ATTACH_FLAG_N_OE,
  output logic [2:0]      O_POWER_STATE,
  output logic [2:0]      O_PROFILE
);

  localparam int TICK_WIDTH = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int TW         = uppsc_pkg::TIMER_WIDTH;

  logic [uppsc_pkg::SYNC_WIDTH-1:0] raw_pins;
  logic [uppsc_pkg::SYNC_WIDTH-1:0] sync_pins;
  uppsc_pkg::uppsc_ctrl_type        ctrl;
  logic                             pol_pin;

  uppsc_pkg::uppsc_state_type state;
  uppsc_pkg::uppsc_state_type next_state;
  uppsc_pkg::uppsc_drive_type drive;
  uppsc_pkg::uppsc_drive_type next_drive;
  logic                       attached;
  logic                       next_attached;
  logic                       alert;
  logic                       next_alert;
  logic                       polarity;
  logic                       next_polarity;
  logic [2:0]                 settle;
  logic [2:0]                 next_settle;
  logic [TW-1:0]              timer;
  logic [TW-1:0]              next_timer;
  logic [2:0]                 profile;
  logic [2:0]                 next_profile;
  logic [TICK_WIDTH-1:0]      tick_count;
  logic [TICK_WIDTH-1:0]      next_tick_count;
  logic                       tick;
  logic                       next_tick;

  logic en_active;
  logic mode_zero;
  logic mode_pass;
  logic mode_cycle;
  logic full_cond;
  logic attach_watch;
  uppsc_pkg::uppsc_state_type target;

  assign raw_pins = {I_ENABLE_POLARITY, I_SWITCH_ENABLE_INPUT, I_DETECT_SELECT,
                     I_EMULATION_ON, I_MODE_SELECT_B, I_MODE_SELECT_A,
                     I_SOURCE_SUPPLY_OK, I_PORTABLE_PRESENT, I_FAULT};

  // every pin, strap included, crosses into the clock domain before decoding
  uppsc_sync #(
    .WIDTH (uppsc_pkg::SYNC_WIDTH)
  ) u_sync (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_async  (raw_pins),
    .o_stable (sync_pins)
  ); // RQ17

  assign pol_pin = sync_pins[uppsc_pkg::SYNC_WIDTH-1];
  assign ctrl    = uppsc_pkg::uppsc_ctrl_type'(sync_pins[uppsc_pkg::SYNC_WIDTH-2:0]);

  // millisecond enable pulse shared by the discharge and profile timers
  always_comb begin
    next_tick       = 1'b0;
    next_tick_count = tick_count + 1'b1;
    if (tick_count == TICK_WIDTH'(TICK_CYCLES - 1)) begin
      next_tick_count = '0;
      next_tick       = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      tick       <= next_tick;
    end
  end

  // decoded input conditions
  always_comb begin
    en_active    = polarity ? ctrl.switch_en : ~ctrl.switch_en;
    mode_zero    = (ctrl.mode == uppsc_pkg::MODE_ALL_ZERO);
    mode_pass    = (ctrl.mode == uppsc_pkg::MODE_PASSTHROUGH);
    mode_cycle   = (ctrl.mode == uppsc_pkg::MODE_CYCLE);
    full_cond    = en_active & ctrl.source_ok & ~mode_zero;
    // the zero-mode configuration sits in detect but never looks for an attach
    attach_watch = ctrl.detect_select & ~(en_active & mode_zero); // RQ13
  end

  // target state from the current control levels, used from sleep, detect, active and error
  always_comb begin
    target = state;
    if (!ctrl.detect_select) begin
      if (!en_active && mode_pass) begin
        // unlisted; holding avoids dropping an active pass-through port mid-transfer
        target = state; // RQ12
      end else if (full_cond) begin
        target = uppsc_pkg::ST_ACTIVE; // RQ9
      end else begin
        target = uppsc_pkg::ST_SLEEP; // RQ5
      end
    end else if (state == uppsc_pkg::ST_ACTIVE && attached && full_cond) begin
      target = uppsc_pkg::ST_ACTIVE; // RQ11
    end else if (state == uppsc_pkg::ST_DETECT && attached && full_cond) begin
      target = uppsc_pkg::ST_ACTIVE; // RQ7
    end else begin
      target = uppsc_pkg::ST_DETECT; // RQ6
    end
  end

  always_comb begin
    next_state    = state;
    next_attached = attached;
    next_alert    = alert;
    next_polarity = polarity;
    next_settle   = settle;
    next_timer    = timer;
    next_profile  = profile;
    next_drive    = '0;

    unique case (state)
      uppsc_pkg::ST_OFF: begin
        // the synchroniser output is only valid after its fourth edge; catching the strap earlier reads reset zeros
        if (settle == uppsc_pkg::SETTLE_CYCLES) begin
          next_polarity = pol_pin;
          next_state    = uppsc_pkg::ST_SLEEP;
        end else begin
          next_settle = settle + 1'b1;
        end
      end
      uppsc_pkg::ST_SLEEP,
      uppsc_pkg::ST_DETECT,
      uppsc_pkg::ST_ACTIVE,
      uppsc_pkg::ST_ERROR: begin
        if (ctrl.fault) begin
          next_state = uppsc_pkg::ST_ERROR; // RQ15
        end else if (state == uppsc_pkg::ST_DETECT && target == uppsc_pkg::ST_ACTIVE) begin
          next_state = uppsc_pkg::ST_SEQ_STOP; // RQ16
        end else begin
          next_state = target; // RQ4
        end
      end
      uppsc_pkg::ST_SEQ_STOP: begin
        next_state = ctrl.fault ? uppsc_pkg::ST_ERROR : uppsc_pkg::ST_SEQ_BYPASS; // RQ16
      end
      uppsc_pkg::ST_SEQ_BYPASS: begin
        next_timer = TW'(DISCHARGE_MS);
        next_state = ctrl.fault ? uppsc_pkg::ST_ERROR : uppsc_pkg::ST_SEQ_DISCHARGE; // RQ16
      end
      uppsc_pkg::ST_SEQ_DISCHARGE: begin
        if (ctrl.fault) begin
          next_state = uppsc_pkg::ST_ERROR;
        end else if (timer == '0) begin
          next_timer = TW'(PROFILE_DWELL_MS);
          next_state = uppsc_pkg::ST_ACTIVE; // RQ16
        end else if (tick) begin
          next_timer = timer - 1'b1;
        end
      end
    endcase

    // a fresh entry into active restarts the dwell so the mode starts cleanly
    if (next_state == uppsc_pkg::ST_ACTIVE && state != uppsc_pkg::ST_ACTIVE &&
        state != uppsc_pkg::ST_SEQ_DISCHARGE) begin
      next_timer = TW'(PROFILE_DWELL_MS);
    end

    // profile stepping; the starting profile is whatever was left, by design
    if (state == uppsc_pkg::ST_ACTIVE && next_state == uppsc_pkg::ST_ACTIVE && mode_cycle &&
        !ctrl.detect_select && !ctrl.present) begin
      if (timer == '0) begin
        next_timer   = TW'(PROFILE_DWELL_MS);
        next_profile = (profile == 3'(PROFILE_COUNT - 1)) ? uppsc_pkg::PROFILE_RESET : profile + 1'b1;
      end else if (tick) begin
        next_timer = timer - 1'b1;
      end
    end // RQ10

    // attach bookkeeping: removal clears first so a same-cycle attach wins
    if (next_state == uppsc_pkg::ST_SLEEP || !ctrl.detect_select) begin
      next_attached = 1'b0; // RQ3
    end else if (state == uppsc_pkg::ST_ACTIVE && !ctrl.present) begin
      next_attached = 1'b0;
    end
    if (state == uppsc_pkg::ST_DETECT && attach_watch && ctrl.present) begin
      next_attached = 1'b1; // RQ7
    end

    // alert persists past error until the block goes to sleep; entry to error wins
    if (next_state == uppsc_pkg::ST_SLEEP) begin
      next_alert = 1'b0; // RQ3
    end
    if (next_state == uppsc_pkg::ST_ERROR) begin
      next_alert = 1'b1; // RQ15
    end

    unique case (next_state)
      uppsc_pkg::ST_OFF,
      uppsc_pkg::ST_SLEEP,
      uppsc_pkg::ST_ERROR: begin
        next_drive = '0; // RQ2
      end
      uppsc_pkg::ST_DETECT: begin
        next_drive.bypass         = 1'b1; // RQ8
        next_drive.attach_det_en  = attach_watch;
        next_drive.removal_det_en = attach_watch;
      end
      uppsc_pkg::ST_SEQ_STOP: begin
        next_drive.bypass         = 1'b1;
        next_drive.removal_det_en = ctrl.detect_select; // RQ16
      end
      uppsc_pkg::ST_SEQ_BYPASS: begin
        next_drive.removal_det_en = ctrl.detect_select; // RQ16
      end
      uppsc_pkg::ST_SEQ_DISCHARGE: begin
        next_drive.discharge      = 1'b1; // RQ16
        next_drive.removal_det_en = ctrl.detect_select;
      end
      uppsc_pkg::ST_ACTIVE: begin
        next_drive.port           = 1'b1; // RQ9
        next_drive.hs             = uppsc_pkg::HS_MODE_MASK[ctrl.mode] & ~mode_cycle; // RQ10
        next_drive.removal_det_en = ctrl.detect_select; // RQ11
      end
    endcase
    next_drive.alert_oe       = next_alert;
    next_drive.attach_flag_oe = next_attached;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state    <= uppsc_pkg::ST_OFF; // RQ1
      drive    <= '0;
      attached <= 1'b0;
      alert    <= 1'b0;
      polarity <= 1'b0;
      settle   <= 3'h0;
      timer    <= '0;
      profile  <= uppsc_pkg::PROFILE_RESET;
    end else begin
      state    <= next_state;
      drive    <= next_drive;
      attached <= next_attached;
      alert    <= next_alert;
      polarity <= next_polarity;
      settle   <= next_settle;
      timer    <= next_timer;
      profile  <= next_profile;
    end
  end

  // open-drain pins only ever pull low, so their data level is a constant-zero flop
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ALERT_N_OUT       <= 1'b0;
      O_ATTACH_FLAG_N_OUT <= 1'b0;
    end else begin
      O_ALERT_N_OUT       <= 1'b0;
      O_ATTACH_FLAG_N_OUT <= 1'b0;
    end
  end

  assign O_PORT_SWITCH_ON    = drive.port;
  assign O_BYPASS_SWITCH_ON  = drive.bypass;
  assign O_HS_SWITCH_ON      = drive.hs;
  assign O_DISCHARGE_ON      = drive.discharge;
  assign O_ATTACH_DETECT_EN  = drive.attach_det_en;
  assign O_REMOVAL_DETECT_EN = drive.removal_det_en;
  assign O_ALERT_N_OE        = drive.alert_oe;
  assign O_ATTACH_FLAG_N_OE  = drive.attach_flag_oe;
  assign O_POWER_STATE       = state;
  assign O_PROFILE           = profile;

endmodule

// >>> uppsc_pkg.sv
// constants, state codes and carrier types for the port power state controller
package uppsc_pkg;

  localparam int CLK_HZ           = 20_000_000;
  localparam int TICK_MS          = 1;
  localparam int TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
  localparam int DISCHARGE_MS     = 200;
  localparam int PROFILE_DWELL_MS = 1000;
  localparam int PROFILE_COUNT    = 8;
  localparam int TIMER_WIDTH      = 10;
  localparam int SYNC_WIDTH       = 9;

  localparam logic [2:0] SETTLE_CYCLES     = 3'h4;
  localparam logic [2:0] MODE_ALL_ZERO     = 3'h0;
  localparam logic [2:0] MODE_PASSTHROUGH  = 3'h1;
  localparam logic [2:0] MODE_CYCLE        = 3'h7;
  localparam logic [7:0] HS_MODE_MASK      = 8'h06;
  localparam logic [2:0] PROFILE_RESET     = 3'h0;

  typedef enum logic [2:0] {
    ST_OFF           = 3'h0,
    ST_SLEEP         = 3'h1,
    ST_DETECT        = 3'h2,
    ST_SEQ_STOP      = 3'h3,
    ST_SEQ_BYPASS    = 3'h4,
    ST_SEQ_DISCHARGE = 3'h5,
    ST_ACTIVE        = 3'h6,
    ST_ERROR         = 3'h7
  } uppsc_state_type;

  typedef struct packed {
    logic       switch_en;
    logic       detect_select;
    logic [2:0] mode;
    logic       source_ok;
    logic       present;
    logic       fault;
  } uppsc_ctrl_type;

  typedef struct packed {
    logic port;
    logic bypass;
    logic hs;
    logic discharge;
    logic attach_det_en;
    logic removal_det_en;
    logic alert_oe;
    logic attach_flag_oe;
  } uppsc_drive_type;

endpackage

// >>> uppsc_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module uppsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_stable
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_stable;

  // per bit: a level that differs between stages two and three is still in flight
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_stable[i] = (stage2[i] == stage3[i]) ? stage2[i] : o_stable[i];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      o_stable <= '0;
    end else begin
      stage1   <= i_async;
      stage2   <= stage1;
      stage3   <= stage2;
      o_stable <= next_stable;
    end
  end

endmodule

// >>> uppsc_monitor.sv
// concurrent checks on the outputs of the port power state controller
`timescale 1ns/1ps
module uppsc_monitor (
  input wire logic       I_CLK,
  input wire logic       I_RESETN,
  input wire logic       O_PORT_SWITCH_ON,
  input wire logic       O_BYPASS_SWITCH_ON,
  input wire logic       O_HS_SWITCH_ON,
  input wire logic       O_DISCHARGE_ON,
  input wire logic       O_ATTACH_DETECT_EN,
  input wire logic       O_REMOVAL_DETECT_EN,
  input wire logic       O_ALERT_N_OE,
  input wire logic       O_ATTACH_FLAG_N_OE,
  input wire logic [2:0] O_POWER_STATE,
  input wire logic [2:0] O_PROFILE
);
  logic [2:0] st;
  logic       sw;
  assign st = O_POWER_STATE;
  assign sw = O_PORT_SWITCH_ON | O_BYPASS_SWITCH_ON | O_HS_SWITCH_ON;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  sequence s_leave_detect;
    st == uppsc_pkg::ST_DETECT ##1 st != uppsc_pkg::ST_DETECT;
  endsequence
  sequence s_stop_step;
    st == uppsc_pkg::ST_SEQ_STOP;
  endsequence
  a_off_quiet : assert property (disable iff (1'b0) !I_RESETN |-> !sw && st == uppsc_pkg::ST_OFF)
    else $error("switch on while held in reset");
  a_sleep_off : assert property (st == uppsc_pkg::ST_SLEEP |->
    !sw && !O_DISCHARGE_ON && !O_ATTACH_DETECT_EN && !O_REMOVAL_DETECT_EN)
    else $error("sleep with a switch or detector on");
  a_sleep_release : assert property (st == uppsc_pkg::ST_SLEEP |-> !O_ALERT_N_OE && !O_ATTACH_FLAG_N_OE)
    else $error("sleep with alert or flag held");
  a_detect_drive : assert property (st == uppsc_pkg::ST_DETECT |->
    !O_PORT_SWITCH_ON && !O_HS_SWITCH_ON && O_BYPASS_SWITCH_ON)
    else $error("detect switch pattern wrong");
  a_active_port : assert property (st == uppsc_pkg::ST_ACTIVE |-> O_PORT_SWITCH_ON && !O_BYPASS_SWITCH_ON)
    else $error("active without port switch");
  a_error_off : assert property (st == uppsc_pkg::ST_ERROR |-> !sw && O_ALERT_N_OE)
    else $error("error state switch or alert wrong");
  a_no_skip : assert property (s_leave_detect |->
    st inside {uppsc_pkg::ST_SLEEP, uppsc_pkg::ST_SEQ_STOP, uppsc_pkg::ST_ERROR})
    else $error("detect left without stop step");
  // removal watch may lapse only when detect select dropped, which also clears the attach flag
  a_stop_step : assert property (s_stop_step |-> O_BYPASS_SWITCH_ON && !O_ATTACH_DETECT_EN &&
    (O_REMOVAL_DETECT_EN || !O_ATTACH_FLAG_N_OE))
    else $error("stop step detector pattern wrong");
  a_discharge_only : assert property (O_DISCHARGE_ON |-> st == uppsc_pkg::ST_SEQ_DISCHARGE && !sw)
    else $error("discharge outside its step");
  a_port_source : assert property ($rose(O_PORT_SWITCH_ON) |->
    $past(O_POWER_STATE) inside {uppsc_pkg::ST_SLEEP, uppsc_pkg::ST_SEQ_DISCHARGE, uppsc_pkg::ST_ERROR})
    else $error("port switch closed from wrong state");
  a_profile_step : assert property ($changed(O_PROFILE) |->
    $past(O_POWER_STATE) == uppsc_pkg::ST_ACTIVE && !$past(O_HS_SWITCH_ON))
    else $error("profile moved outside cycling");
endmodule
bind uppsc_top uppsc_monitor u_mon (.I_CLK, .I_RESETN, .O_PORT_SWITCH_ON, .O_BYPASS_SWITCH_ON, .O_HS_SWITCH_ON,
  .O_DISCHARGE_ON, .O_ATTACH_DETECT_EN, .O_REMOVAL_DETECT_EN, .O_ALERT_N_OE, .O_ATTACH_FLAG_N_OE,
  .O_POWER_STATE, .O_PROFILE);

// >>> uppsc_portable_model.sv
// portable device model: reports presence after a settable plug-in delay
`timescale 1ns/1ps
module uppsc_portable_model (
  input  wire logic       i_clk,
  input  wire logic       i_plug,
  input  wire logic [3:0] i_delay,
  output logic            o_present
);
  logic [3:0] wait_cnt = 4'h0;
  initial o_present = 1'b0;
  // removal is seen at once, insertion only after the contact settles
  always @(negedge i_clk) begin
    if (!i_plug) begin
      o_present <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt < i_delay) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      o_present <= 1'b1;
    end
  end
endmodule

// >>> tb_uppsc_top.sv
// self-checking bench for the port power state controller
`timescale 1ns/1ps
module tb_uppsc_top;
  localparam int TICK  = 4;
  localparam int DWELL = 3;
  logic I_CLK, I_RESETN, I_ENABLE_POLARITY, I_SWITCH_ENABLE_INPUT, I_DETECT_SELECT, I_FAULT;
  logic I_MODE_SELECT_A, I_MODE_SELECT_B, I_EMULATION_ON, I_SOURCE_SUPPLY_OK;
  wire logic I_PORTABLE_PRESENT;
  logic O_PORT_SWITCH_ON, O_BYPASS_SWITCH_ON, O_HS_SWITCH_ON, O_DISCHARGE_ON, O_ATTACH_DETECT_EN;
  logic O_REMOVAL_DETECT_EN, O_ALERT_N_OUT, O_ALERT_N_OE, O_ATTACH_FLAG_N_OUT, O_ATTACH_FLAG_N_OE;
  logic [2:0] O_POWER_STATE, O_PROFILE, p;
  uppsc_pkg::uppsc_ctrl_type c = '0;
  logic        pol = 1'b1;
  logic        plug = 1'b0;
  logic        alert = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [31:0] seed = 32'h0000_4d52;
  logic [31:0] path;
  int          err_count = 0;
  int          total_checks = 0;
  assign I_SWITCH_ENABLE_INPUT = c.switch_en ~^ pol;
  assign I_ENABLE_POLARITY = pol;
  assign I_DETECT_SELECT = c.detect_select;
  assign {I_EMULATION_ON, I_MODE_SELECT_B, I_MODE_SELECT_A} = c.mode;
  assign I_SOURCE_SUPPLY_OK = c.source_ok;
  assign I_FAULT = c.fault;
  uppsc_top #(.TICK_CYCLES(TICK), .DISCHARGE_MS(2), .PROFILE_DWELL_MS(DWELL), .PROFILE_COUNT(8)) DUT (
    .I_CLK, .I_RESETN, .I_SWITCH_ENABLE_INPUT, .I_ENABLE_POLARITY, .I_DETECT_SELECT, .I_MODE_SELECT_A,
    .I_MODE_SELECT_B, .I_EMULATION_ON, .I_SOURCE_SUPPLY_OK, .I_PORTABLE_PRESENT, .I_FAULT, .O_PORT_SWITCH_ON,
    .O_BYPASS_SWITCH_ON, .O_HS_SWITCH_ON, .O_DISCHARGE_ON, .O_ATTACH_DETECT_EN, .O_REMOVAL_DETECT_EN,
    .O_ALERT_N_OUT, .O_ALERT_N_OE, .O_ATTACH_FLAG_N_OUT, .O_ATTACH_FLAG_N_OE, .O_POWER_STATE, .O_PROFILE);
  uppsc_portable_model PDEV (.i_clk(I_CLK), .i_plug(plug), .i_delay(dly), .o_present(I_PORTABLE_PRESENT));
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  // only for pin sets with nothing attached
  function automatic logic [2:0] exp_state(input uppsc_pkg::uppsc_ctrl_type k);
    if (k.fault) return uppsc_pkg::ST_ERROR;
    if (k.detect_select) return uppsc_pkg::ST_DETECT;
    if (k.switch_en && k.mode != 3'h0 && k.source_ok) return uppsc_pkg::ST_ACTIVE;
    return uppsc_pkg::ST_SLEEP;
  endfunction
  task automatic finish_test();
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic drive(input uppsc_pkg::uppsc_ctrl_type k, input int n);
    @(negedge I_CLK);
    c = k;
    repeat (n) @(negedge I_CLK);
  endtask
  task automatic chk_drive(input logic [2:0] st, input logic [2:0] m);
    chk({29'h0, O_POWER_STATE}, {29'h0, st});
    chk({O_PORT_SWITCH_ON, O_BYPASS_SWITCH_ON, O_HS_SWITCH_ON, O_DISCHARGE_ON, O_ALERT_N_OE, O_ATTACH_FLAG_N_OE,
         O_ALERT_N_OUT, O_ATTACH_FLAG_N_OUT}, {st == 3'h6, st == 3'h2, st == 3'h6 && uppsc_pkg::HS_MODE_MASK[m], 1'b0,
         alert, 1'b0, 2'b00});
  endtask
  task automatic run_random(input int n);
    uppsc_pkg::uppsc_ctrl_type k;
    logic [2:0] e;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      k = uppsc_pkg::uppsc_ctrl_type'(seed[7:0]);
      k.present = 1'b0;
      k.fault = seed[9] & seed[8];
      // pass-through with enable off and select 0 is unlisted, so mode 2 replaces it in the same pin set
      if (!k.detect_select && !k.switch_en && k.mode == uppsc_pkg::MODE_PASSTHROUGH) k.mode = 3'h2;
      // long enough for a detect-to-active sequence with its discharge step
      drive(k, 24);
      e = exp_state(k);
      if (e == uppsc_pkg::ST_ERROR) alert = 1'b1;
      else if (e == uppsc_pkg::ST_SLEEP) alert = 1'b0;
      chk_drive(e, k.mode);
      if (e == 3'h2 && k.switch_en && k.mode == 3'h0) chk({31'h0, O_ATTACH_DETECT_EN}, 32'h0);
    end
  endtask
  initial begin
    repeat (20000) @(posedge I_CLK);
    err_count++;
    finish_test();
  end
  initial begin
    uppsc_pkg::uppsc_ctrl_type k;
    I_RESETN = 1'b0;
    repeat (10) @(negedge I_CLK);
    I_RESETN = 1'b1;
    run_random(40);
    alert = 1'b0;
    drive('0, 12);
    k = '0;
    k.switch_en = 1'b1;
    k.detect_select = 1'b1;
    k.mode = 3'h2;
    k.source_ok = 1'b1;
    for (int j = 0; j < 2; j++) begin
      drive(k, 12);
      chk({30'h0, O_ATTACH_DETECT_EN, O_REMOVAL_DETECT_EN}, 32'h3);
      dly = j ? 4'hc : 4'h0;
      plug = 1'b1;
      path = 32'h2;
      for (int n = 0; n < 200 && O_POWER_STATE !== 3'h6; n++) begin
        @(negedge I_CLK);
        if (O_POWER_STATE !== path[2:0]) path = {path[27:0], 1'b0, O_POWER_STATE};
        if (O_POWER_STATE === 3'h5) chk({31'h0, O_DISCHARGE_ON}, 32'h1);
      end
      chk(path, 32'h0002_3456);
      chk({29'h0, O_PORT_SWITCH_ON, O_REMOVAL_DETECT_EN, O_ATTACH_FLAG_N_OE}, 32'h7);
      plug = 1'b0;
      drive(k, 12);
      chk({29'h0, O_POWER_STATE}, 32'h2);
    end
    drive('0, 12);
    k.detect_select = 1'b0;
    @(negedge I_CLK);
    c = k;
    @(negedge I_CLK);
    c = '0;
    for (int n = 0; n < 12; n++) begin
      @(negedge I_CLK);
      chk({29'h0, O_POWER_STATE}, 32'h1);
    end
    k.mode = uppsc_pkg::MODE_PASSTHROUGH;
    drive(k, 12);
    chk_drive(3'h6, k.mode);
    k.mode = uppsc_pkg::MODE_ALL_ZERO;
    drive(k, 12);
    chk_drive(3'h1, k.mode);
    k.switch_en = 1'b0;
    drive(k, 12);
    chk_drive(3'h1, k.mode);
    k.switch_en = 1'b1;
    k.mode = uppsc_pkg::MODE_CYCLE;
    drive(k, 12);
    chk_drive(3'h6, 3'h7);
    for (int s = 0; s < 9; s++) begin
      p = O_PROFILE;
      for (int n = 0; n < 3 * DWELL * TICK + 8 && O_PROFILE === p; n++) @(negedge I_CLK);
      chk({29'h0, O_PROFILE}, {29'h0, p + 3'h1});
    end
    I_RESETN = 1'b0;
    repeat (2) @(negedge I_CLK);
    chk({O_POWER_STATE, O_PORT_SWITCH_ON, O_BYPASS_SWITCH_ON, O_HS_SWITCH_ON, O_ALERT_N_OE}, 32'h0);
    pol = 1'b0;
    c = '0;
    I_RESETN = 1'b1;
    repeat (12) @(negedge I_CLK);
    chk_drive(3'h1, 3'h0);
    run_random(20);
    finish_test();
  end
endmodule
